// File: dds_pkg.sv
`default_nettype none

package dds_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int ACC_W = 32;
   localparam int PHASE_W = 14;
   localparam int DAC_W = 10;
   localparam int FIFO_DEPTH = 8;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_MIN_PERIOD_NS = 1000;
   // Longest allowed gap between reference edges, rounded down
   localparam int LOSS_CYC = REF_MIN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RST_LATENCY_CYC = 13;
   localparam int RST_MIN_CYC = 5;
   localparam int RST_RECOVERY_CYC = 2;
   // Counted from release, so a minimal reset gives the full latency
   localparam int RST_AFTER_CYC = RST_LATENCY_CYC - RST_MIN_CYC;

   // ****************************************************************
   // Reset values and cosine mapping constants
   // ****************************************************************
   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
   localparam logic [ACC_W-1:0] FTW_RESET = 32'h0000_0000;
   localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
   localparam logic [DAC_W-1:0] COS_ZERO = 10'h3FF;
   localparam logic [PHASE_W-1:0] PHASE_QUARTER = 14'h1000;
   localparam logic signed [PHASE_W-1:0] HALF_CENTRE = 14'sh1000;
   localparam logic [27:0] PARAB_PEAK = 28'h100_0000;
   localparam int PARAB_SHIFT = 15;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic pwr_down;
      logic [ACC_W-1:0] tuning_word;
   } dds_load_t;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RECOVER = 2'b01,
      ST_RUN = 2'b11,
      ST_SLEEP = 2'b10
   } dds_state_t;

endpackage

`default_nettype wire

// File: dds_fifo.sv
`default_nettype none

module dds_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic mclk, // Core clock
   input wire logic rstn, // Sync reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word written
   output logic out_valid, // Word available
   input wire logic out_ready, // Read request
   output logic [WIDTH-1:0] out_data // Oldest word
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (WIDTH < 1 || DEPTH < 2)
      begin : g_bad
         $error("dds_fifo: WIDTH must be >= 1 and DEPTH >= 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic do_wr;
   logic do_rd;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_ff @(posedge mclk)
   begin
      if (do_wr)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd)
         begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         count <= '0;
      end
      else if (do_wr && !do_rd)
      begin
         count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
         count <= count - 1'b1;
      end
   end

endmodule

`default_nettype wire

// File: dds_core.sv
// Contract
// - Each reference clock rising edge adds the tuning word into the phase accumulator; the code skips an edge met with a full sample buffer.
// - Accumulator overflow drops the carry and wraps modulo two to the 32.
// - Truncated 14-bit phase is mapped to its cosine amplitude.
// - Output frequency equals tuning word times reference rate over two to the 32.
// - Every cosine sample goes to the DAC as a 10-bit word.
// - A new tuning word never clears or reloads the accumulator.
// - Reference clock slower than 1 MHz forces automatic power-down.
// - Synthesis resumes by itself once the reference clock is fast again.
// - Update strobe rising edge moves the loaded word into the active register.
// - Reset clears frequency register and power-down bit, output heads to cosine zero.
// - Reset output latency 13 cycles, minimum width 5, recovery 2 cycles.
`default_nettype none

module dds_core #(
   parameter int FIFO_DEPTH = dds_pkg::FIFO_DEPTH,
   parameter int LOSS_CYC = dds_pkg::LOSS_CYC
) (
   input wire logic mclk, // Core clock, 100 MHz
   input wire logic rstn, // Master reset, sync, active low
   input wire logic ref_clock_in, // Reference clock, sampled
   input wire logic freq_update_strobe, // Rising edge commits loaded word
   input wire dds_pkg::dds_load_t load_word, // Data input register contents
   input wire logic dac_ready, // DAC takes the sample
   output logic dac_valid, // Sample presented
   output logic [dds_pkg::DAC_W-1:0] dac_word, // Cosine sample, offset binary
   output logic power_down, // Core idle, either cause
   output logic clock_lost // Reference below minimum rate
);

   generate
      if (FIFO_DEPTH < 2 || LOSS_CYC < 2)
      begin : g_bad
         $error("dds_core: FIFO_DEPTH and LOSS_CYC must be >= 2");
      end
   endgenerate

   localparam int GAP_W = $clog2(LOSS_CYC + 1);
   localparam int AGE_W = $clog2(dds_pkg::RST_AFTER_CYC + 1);

   // ****************************************************************
   // Cosine mapping
   // ****************************************************************
   // Parabolic half-wave fit: no table storage, up to about 29 LSB of error.
   function automatic logic [dds_pkg::DAC_W-1:0] cos_of(input logic [dds_pkg::PHASE_W-1:0] ph);
      logic [dds_pkg::PHASE_W-1:0] ps;
      logic signed [dds_pkg::PHASE_W-1:0] d;
      logic [27:0] sq;
      logic [10:0] mag;
      logic [10:0] v;
      ps = ph + dds_pkg::PHASE_QUARTER;
      d = $signed({1'b0, ps[dds_pkg::PHASE_W-2:0]}) - dds_pkg::HALF_CENTRE;
      sq = 28'(d * d);
      mag = 11'((dds_pkg::PARAB_PEAK - sq) >> dds_pkg::PARAB_SHIFT);
      if (ps[dds_pkg::PHASE_W-1])
      begin
         v = 11'({1'b0, dds_pkg::DAC_MID}) - mag;
      end
      else
      begin
         v = 11'({1'b0, dds_pkg::DAC_MID}) + mag;
      end
      if (v > 11'({1'b0, dds_pkg::COS_ZERO}))
      begin
         v = 11'({1'b0, dds_pkg::COS_ZERO});
      end
      return v[dds_pkg::DAC_W-1:0];
   endfunction

   // ****************************************************************
   // Input edge detection
   // ****************************************************************
   logic ref_q;
   logic ref_qq;
   logic upd_q;
   logic upd_qq;
   logic ref_rise;
   logic upd_rise;

   always_ff @(posedge mclk)
   begin
      ref_q <= ref_clock_in;
      ref_qq <= ref_q;
      upd_q <= freq_update_strobe;
      upd_qq <= upd_q;
   end

   assign ref_rise = ref_q && !ref_qq;
   assign upd_rise = upd_q && !upd_qq;

   // ****************************************************************
   // Active frequency register and power-down bit
   // ****************************************************************
   logic [dds_pkg::ACC_W-1:0] ftw;
   logic pd_bit;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         ftw <= dds_pkg::FTW_RESET;
         pd_bit <= 1'b0;
      end
      else if (upd_rise)
      begin
         ftw <= load_word.tuning_word;
         pd_bit <= load_word.pwr_down;
      end
   end

   // ****************************************************************
   // Reference clock loss detection
   // ****************************************************************
   logic [GAP_W-1:0] gap;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         gap <= '0;
      end
      else if (ref_rise)
      begin
         gap <= '0;
      end
      else if (gap != GAP_W'(LOSS_CYC))
      begin
         gap <= gap + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         clock_lost <= 1'b0;
      end
      else if (gap == GAP_W'(LOSS_CYC))
      begin
         clock_lost <= 1'b1;
      end
      else if (ref_rise)
      begin
         clock_lost <= 1'b0;
      end
   end

   // ****************************************************************
   // Reset aftermath and state
   // ****************************************************************
   logic [AGE_W-1:0] age;
   logic age_done;
   dds_pkg::dds_state_t state;
   logic sleep_req;

   assign age_done = (age == AGE_W'(dds_pkg::RST_AFTER_CYC));
   assign sleep_req = pd_bit || clock_lost;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         age <= '0;
      end
      else if (!age_done)
      begin
         age <= age + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state <= dds_pkg::ST_RESET;
      end
      else
      begin
         case (state)
            dds_pkg::ST_RESET: state <= dds_pkg::ST_RECOVER;
            dds_pkg::ST_RECOVER:
            begin
               // Second cycle after release; steps start after recovery
               if (age >= AGE_W'(dds_pkg::RST_RECOVERY_CYC - 1))
               begin
                  state <= sleep_req ? dds_pkg::ST_SLEEP : dds_pkg::ST_RUN;
               end
            end
            dds_pkg::ST_RUN:
            begin
               if (sleep_req)
               begin
                  state <= dds_pkg::ST_SLEEP;
               end
            end
            dds_pkg::ST_SLEEP:
            begin
               if (!sleep_req)
               begin
                  state <= dds_pkg::ST_RUN;
               end
            end
            default: state <= dds_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         power_down <= 1'b0;
      end
      else
      begin
         power_down <= (state == dds_pkg::ST_SLEEP);
      end
   end

   // ****************************************************************
   // Phase accumulator and sample generation
   // ****************************************************************
   logic [dds_pkg::ACC_W-1:0] acc;
   logic push_valid;
   logic [dds_pkg::DAC_W-1:0] push_data;
   logic fifo_in_ready;
   logic step;

   // A reference edge met with a full buffer is skipped: the phase stalls
   assign step = ref_rise && (state == dds_pkg::ST_RUN) && !sleep_req && fifo_in_ready && !push_valid;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         acc <= dds_pkg::ACC_RESET;
      end
      else if (step)
      begin
         // Carry out of bit 31 is dropped; never reloaded on update
         acc <= dds_pkg::ACC_W'(acc + ftw);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         push_valid <= 1'b0;
         push_data <= dds_pkg::DAC_MID;
      end
      else
      begin
         push_valid <= step;
         if (step)
         begin
            push_data <= cos_of(acc[dds_pkg::ACC_W-1 -: dds_pkg::PHASE_W]);
         end
      end
   end

   // ****************************************************************
   // Sample buffer and DAC port
   // ****************************************************************
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [dds_pkg::DAC_W-1:0] fifo_out_data;

   assign fifo_out_ready = age_done && (!dac_valid || dac_ready);

   dds_fifo #(
      .WIDTH(dds_pkg::DAC_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         dac_valid <= 1'b0;
         dac_word <= dds_pkg::DAC_MID;
      end
      else if (age == AGE_W'(dds_pkg::RST_AFTER_CYC - 1))
      begin
         dac_word <= dds_pkg::COS_ZERO;
      end
      else if (fifo_out_ready)
      begin
         dac_valid <= fifo_out_valid;
         if (fifo_out_valid)
         begin
            dac_word <= fifo_out_data;
         end
      end
   end

endmodule

`default_nettype wire

// File: dds_core_asserts.sv
`default_nettype none

module dds_core_asserts #(
   parameter int LOSS_CYC = 100
) (
   input wire logic mclk, // Core clock
   input wire logic rstn, // Sync reset
   input wire logic ref_clock_in, // Reference level
   input wire logic freq_update_strobe, // Update strobe
   input wire dds_pkg::dds_load_t load_word, // Loaded word
   input wire logic dac_ready, // DAC accepts
   input wire logic dac_valid, // Sample offered
   input wire logic [dds_pkg::DAC_W-1:0] dac_word, // Sample
   input wire logic power_down, // Idle
   input wire logic clock_lost // Loss flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // ******
   // Gap since the last sampled reference rise
   // ******
   logic ref_prev;
   logic [7:0] gap;
   always_ff @(posedge mclk)
   begin
      ref_prev <= ref_clock_in;
   end
   always_ff @(posedge mclk)
   begin
      if (!rstn || (ref_clock_in && !ref_prev))
      begin
         gap <= 8'h00;
      end
      else if (gap != 8'hFF)
      begin
         gap <= gap + 8'h01;
      end
   end

   // ******
   // Properties
   // ******
   sequence s_strobe;
      !freq_update_strobe ##1 freq_update_strobe;
   endsequence
   sequence s_quiet;
      !dac_valid [*8];
   endsequence
   sequence s_ref_rise;
      !ref_clock_in ##1 ref_clock_in;
   endsequence
   // Reset itself is the cause here, so no disable
   property p_rst_out;
      @(posedge mclk) !rstn |=> dac_word == dds_pkg::DAC_MID && !dac_valid && !power_down && !clock_lost;
   endproperty
   property p_lat;
      @(posedge mclk) disable iff (!rstn) $rose(rstn) |-> s_quiet ##1 dac_word == dds_pkg::COS_ZERO;
   endproperty
   property p_hold;
      @(posedge mclk) disable iff (!rstn) dac_valid && !dac_ready |=> dac_valid && $stable(dac_word);
   endproperty
   property p_lost;
      @(posedge mclk) disable iff (!rstn) gap == 8'(LOSS_CYC + 6) |-> clock_lost ##[0:3] power_down;
   endproperty
   // An edge that ends a long gap cannot clear the flag; only a short gap proves the rate
   property p_nolost;
      @(posedge mclk) disable iff (!rstn) gap == 8'h05 && $past(gap, 6) < 8'(LOSS_CYC) |-> !clock_lost;
   endproperty
   property p_pd_bit;
      @(posedge mclk) disable iff (!rstn) s_strobe ##0 load_word.pwr_down |-> ##[1:6] power_down;
   endproperty
   property p_pd_off;
      @(posedge mclk) disable iff (!rstn) s_strobe ##0 !load_word.pwr_down |-> ##[1:6] (!power_down || clock_lost);
   endproperty
   property p_step;
      @(posedge mclk) disable iff (!rstn)
         s_ref_rise ##0 ($past(rstn, 4) && !power_down && !clock_lost && !freq_update_strobe && !dac_valid)
         |-> ##[2:6] dac_valid;
   endproperty

   a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong");
   a_lat: assert property (p_lat) else $error("reset latency wrong");
   a_hold: assert property (p_hold) else $error("sample not held");
   a_lost: assert property (p_lost) else $error("slow clock not detected");
   a_nolost: assert property (p_nolost) else $error("loss flag stuck");
   a_pd_bit: assert property (p_pd_bit) else $error("power-down bit ignored");
   a_pd_off: assert property (p_pd_off) else $error("did not wake");
   a_step: assert property (p_step) else $error("no sample for edge");
endmodule

`default_nettype wire

// File: dds_dac_model.sv
`default_nettype none

module dds_dac_model (
   input wire logic mclk, // Core clock
   input wire logic rstn, // Reset
   input wire logic stall, // Refuse all samples
   input wire logic dac_valid, // Sample offered
   input wire logic [dds_pkg::DAC_W-1:0] dac_word, // Sample
   output logic dac_ready // Sample taken
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 2;
   logic [dds_pkg::DAC_W-1:0] level;
   // Random pacing, so the core sees both prompt and slow takes
   always @(negedge mclk)
   begin
      dac_ready <= !stall && rstn && 1'($random(seed));
   end
   always @(posedge mclk)
   begin
      if (dac_valid && dac_ready)
      begin
         level <= dac_word;
      end
   end
endmodule

`default_nettype wire

// File: dds_core_tb_top.sv
`default_nettype none

`define CHK(g, e, t) \
   begin \
      checked++; \
      if ($isunknown(g) || ((int'(g) > (e)) ? int'(g) - (e) : (e) - int'(g)) > (t)) \
      begin \
         errors++; \
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); \
      end \
   end

module dds_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOSS = 60;
   // Loose: the core's cosine is an approximation
   localparam int TOL = 32;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ref_clock_in = 1'b0;
   logic freq_update_strobe = 1'b0;
   dds_pkg::dds_load_t load_word = {1'b0, 32'h1234_5678};
   logic stall = 1'b0;
   logic dac_ready;
   logic dac_valid;
   logic [dds_pkg::DAC_W-1:0] dac_word;
   logic power_down;
   logic clock_lost;
   int errors = 0;
   int checked = 0;
   int seed = 2;
   int cycles = 0;
   int exp_v;
   int exp_q[$];
   logic [31:0] acc = 32'h0;
   logic [31:0] ftw = 32'h0;

   dds_core #(.FIFO_DEPTH(8), .LOSS_CYC(LOSS)) u_dut (.mclk(mclk), .rstn(rstn), .ref_clock_in(ref_clock_in),
      .freq_update_strobe(freq_update_strobe), .load_word(load_word), .dac_ready(dac_ready),
      .dac_valid(dac_valid), .dac_word(dac_word), .power_down(power_down), .clock_lost(clock_lost));
   dds_dac_model u_dac (.mclk(mclk), .rstn(rstn), .stall(stall), .dac_valid(dac_valid), .dac_word(dac_word),
      .dac_ready(dac_ready));

   always #5 mclk = ~mclk;

   function automatic int cosx(logic [31:0] a);
      return int'($floor(511.5 + 511.5 * $cos(6.283185307 * a[31:18] / 16384.0) + 0.5));
   endfunction

   // ******
   // Stimulus tasks
   // ******
   task automatic pulses(input int n, input bit note, input bit skip);
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk);
         ref_clock_in = 1'b1;
         // After a loss, the first edge only restarts the gap count; the second clears the flag
         if (note && !(skip && i < 2))
         begin
            exp_q.push_back(cosx(acc));
            acc = acc + ftw;
         end
         repeat (3) @(negedge mclk);
         ref_clock_in = 1'b0;
         repeat (2) @(negedge mclk);
      end
   endtask

   task automatic commit(input bit pd, input logic [31:0] w);
      @(negedge mclk);
      load_word = {pd, w};
      @(negedge mclk);
      freq_update_strobe = 1'b1;
      repeat (6) @(negedge mclk);
      freq_update_strobe = 1'b0;
      ftw = w;
      repeat (3) @(negedge mclk);
      `CHK(power_down, pd, 0)
   endtask

   task automatic drain();
      for (int i = 0; i < 100 && exp_q.size() != 0; i++)
      begin
         @(negedge mclk);
      end
      repeat (4) @(negedge mclk);
      `CHK(exp_q.size(), 0, 0)
   endtask

   task automatic final_report();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ******
   // Output watcher and timeout
   // ******
   always @(posedge mclk)
   begin
      if (rstn && dac_valid === 1'b1 && dac_ready === 1'b1)
      begin
         `CHK(exp_q.size() > 0, 1, 0)
         if (exp_q.size() > 0)
         begin
            exp_v = exp_q.pop_front();
            `CHK(dac_word, exp_v, TOL)
         end
      end
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         errors++;
         final_report();
      end
   end

   initial
   begin
      repeat (3) @(negedge mclk);
      `CHK(dac_word, dds_pkg::DAC_MID, 0)
      rstn = 1'b1;
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      `CHK(dac_word, dds_pkg::DAC_MID, 0)
      @(negedge mclk);
      `CHK(dac_word, dds_pkg::COS_ZERO, 0)
      repeat (LOSS + 20) @(negedge mclk);
      `CHK(clock_lost, 1, 0)
      `CHK(power_down, 1, 0)
      pulses(4, 1'b1, 1'b1);
      `CHK(clock_lost, 0, 0)
      drain();
      $display("test reset and clock loss done");
      for (int k = 0; k < 3; k++)
      begin
         commit(1'b0, k == 0 ? 32'h1000_0000 : {2'b00, 30'($random(seed))});
         pulses(20, 1'b1, 1'b0);
         drain();
      end
      $display("test tuning done");
      stall = 1'b1;
      pulses(8, 1'b1, 1'b0);
      `CHK(dac_valid, 1, 0)
      stall = 1'b0;
      drain();
      $display("test stall done");
      commit(1'b1, ftw);
      pulses(3, 1'b0, 1'b0);
      commit(1'b0, ftw);
      pulses(6, 1'b1, 1'b0);
      drain();
      $display("test power-down done");
      @(negedge mclk);
      rstn = 1'b0;
      repeat (5) @(negedge mclk);
      rstn = 1'b1;
      acc = 32'h0;
      ftw = 32'h0;
      repeat (10) @(negedge mclk);
      pulses(4, 1'b1, 1'b0);
      drain();
      $display("test second reset done");
      final_report();
   end
endmodule

bind dds_core dds_core_asserts #(.LOSS_CYC(LOSS_CYC)) u_chk (.mclk(mclk), .rstn(rstn), .ref_clock_in(ref_clock_in),
   .freq_update_strobe(freq_update_strobe), .load_word(load_word), .dac_ready(dac_ready), .dac_valid(dac_valid),
   .dac_word(dac_word), .power_down(power_down), .clock_lost(clock_lost));

`default_nettype wire
